/* inc/vml_pkg.sv */
// package: register map, field layout, reset values, gain tables, timing
// assumes: one 40 MHz clock, byte-wide register port, signed samples
// Operation
// - woofer trim boosts low branch, 1 dB at 0010
// - tweeter trim boosts high branch 0.5 dB/step
// - main code: 0 +24 dB, 0x30 unity, ff mute
// - channel codes same encoding, ff mutes channel
// - bass code same encoding as main level
// - converter flip negates converter samples
// - channel flip inverts pwm, not aux or delay
// - bass flip inverts bass pwm, not aux
// - converter silence forces converter output to zero
// - channel silence mutes pwm and aux, delay passes
// - bass silence mutes bass pwm and aux
// - channel and bass silence changes follow ramp and crossing mode
// - upper threshold code picks attack level
// - lower threshold code picks release level
// - zero cross per channel with timeout fallback
// - limiter attenuates only when enabled
// - global link limits all channels on clip
package vml_pkg;
  localparam logic [7:0] OFS_RAMP = 8'h55;
  localparam logic [7:0] OFS_TRIM = 8'h56;
  localparam logic [7:0] OFS_MAIN = 8'h57;
  localparam logic [7:0] OFS_CHA  = 8'h58;
  localparam logic [7:0] OFS_CHB  = 8'h59;
  localparam logic [7:0] OFS_BASS = 8'h5a;
  localparam logic [7:0] OFS_SIL  = 8'h5b;
  localparam logic [7:0] OFS_LIM  = 8'h5c;
  localparam logic [7:0] OFS_STAT = 8'h62;
  localparam logic [7:0] RST_RAMP = 8'h80;
  localparam logic [7:0] RST_TRIM = 8'h00;
  localparam logic [7:0] RST_MAIN = 8'h2a;
  localparam logic [7:0] RST_LVL  = 8'h30;
  localparam logic [7:0] RST_SIL  = 8'h00;
  localparam logic [7:0] RST_LIM  = 8'h02;
  localparam int B_SIL_A = 0;
  localparam int B_SIL_B = 1;
  localparam int B_SIL_BASS = 2;
  localparam int B_SIL_ADC = 3;
  localparam int B_INV_A = 4;
  localparam int B_INV_B = 5;
  localparam int B_INV_BASS = 6;
  localparam int B_INV_ADC = 7;
  localparam int B_LIM_ON = 0;
  localparam int B_LIM_LINK = 1;
  localparam int F_UPPER = 5;
  localparam int F_LOWER = 2;
  localparam int F_WOOF = 4;
  localparam int F_RAMP = 6;
  localparam logic [7:0] MUTE_CODE = 8'hff;
  localparam logic [10:0] BOOST_HDB = 11'h030;
  localparam logic [9:0] MUTE_HDB = 10'h12c;
  localparam logic [3:0] WOOF_MAX = 4'he;
  localparam logic [5:0] LIM_MAX = 6'h3f;
  localparam int RAMP_SAMPLES = 4;
  localparam int ZC_TIMEOUT_NS = 18_700_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int ZC_TIMEOUT_CYC = ZC_TIMEOUT_NS / CLK_PERIOD_NS;
  typedef enum logic [3:0] {
    MODE_IMM  = 4'b0001,
    MODE_ZC   = 4'b0010,
    MODE_RAMP = 4'b0100,
    MODE_RZC  = 4'b1000
  } vml_mode_t;
  // gain of one half-decibel step within an octave, q15
  function automatic logic [15:0] mant(input logic [3:0] k);
    logic [15:0] m;
    m = 16'h43ce;
    unique case (k)
      4'h0: m = 16'h8000;
      4'h1: m = 16'h78d1;
      4'h2: m = 16'h7209;
      4'h3: m = 16'h6ba2;
      4'h4: m = 16'h6598;
      4'h5: m = 16'h5fe4;
      4'h6: m = 16'h5a82;
      4'h7: m = 16'h556e;
      4'h8: m = 16'h50a3;
      4'h9: m = 16'h4c1c;
      4'ha: m = 16'h47d6;
      default: m = 16'h43ce;
    endcase
    return m;
  endfunction
endpackage

/* logic/vml_gain_ch.sv */
// file: one gain stage with ramp and zero-cross level tracking
// assumes: target in half-dB below +24 dB, samples strobed by in_valid
`timescale 1ns/10ps
module vml_gain_ch #(
  parameter int W   = 16,
  parameter int TMO = vml_pkg::ZC_TIMEOUT_CYC
) (
  input  logic                clock,
  input  logic                resetn,
  input  vml_pkg::vml_mode_t  mode,
  input  logic [9:0]          target,
  input  logic                in_valid,
  input  logic signed [W-1:0] in_data,
  output logic                out_valid,
  output logic signed [W-1:0] out_data,
  output logic [9:0]          level
);
  localparam int TW = $clog2(TMO + 1);
  logic signed [W-1:0]  prev;
  logic [TW-1:0]        tmo_cnt;
  logic [2:0]           ramp_cnt;
  logic                 zc;
  logic                 tmo;
  logic                 pend;
  logic [9:0]           step;
  logic [9:0]           oct;
  logic [9:0]           frac;
  logic signed [W+16:0] prod;
  logic signed [W+20:0] sh;
  logic signed [W-1:0]  next_out;

  assign zc = in_valid && (in_data == '0 || in_data[W-1] != prev[W-1]);
  assign tmo = tmo_cnt == TW'(TMO);
  assign pend = level != target;
  assign step = level < target ? level + 10'h001 :
                pend ? level - 10'h001 : level;

  always_ff @(posedge clock)
    if (!resetn)
      prev <= '0;
    else if (in_valid)
      prev <= in_data;

  always_ff @(posedge clock)
    if (!resetn || !pend || zc || tmo)
      tmo_cnt <= '0;
    else
      tmo_cnt <= tmo_cnt + TW'(1);

  always_ff @(posedge clock)
    if (!resetn)
      ramp_cnt <= '0;
    else if (in_valid)
      ramp_cnt <= ramp_cnt == 3'(vml_pkg::RAMP_SAMPLES - 1) ?
                  3'h0 : ramp_cnt + 3'h1;

  always_ff @(posedge clock)
    if (!resetn)
      level <= vml_pkg::MUTE_HDB;
    else
      unique case (mode)
        vml_pkg::MODE_IMM: if (in_valid) level <= target;
        vml_pkg::MODE_ZC: if (zc || tmo) level <= target;
        vml_pkg::MODE_RAMP:
          if (in_valid && ramp_cnt == 3'(vml_pkg::RAMP_SAMPLES - 1))
            level <= step;
        vml_pkg::MODE_RZC: if (zc || tmo) level <= step;
      endcase

  always_comb
  begin
    oct = level / 10'd12;
    frac = level % 10'd12;
    prod = in_data * $signed({1'b0, vml_pkg::mant(frac[3:0])});
    sh = $signed({prod, 4'h0}) >>> (oct + 10'd15);
    if (level >= vml_pkg::MUTE_HDB)
      next_out = '0;
    else if (sh[W+20:W-1] == '0 || sh[W+20:W-1] == '1)
      next_out = sh[W-1:0];
    else
      next_out = sh[W+20] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
  end

  always_ff @(posedge clock)
    if (!resetn)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
        out_data <= next_out;
    end

  imm_apply_a: assert property (@(posedge clock) disable iff (!resetn)
    mode == vml_pkg::MODE_IMM && in_valid |=> level == $past(target))
    else $error("immediate level change not applied");
  ramp_step_a: assert property (@(posedge clock) disable iff (!resetn)
    mode == vml_pkg::MODE_RAMP |=> level == $past(level) ||
    level == $past(level) + 10'h001 || level == $past(level) - 10'h001)
    else $error("soft ramp step larger than half decibel");
  zc_tmo_a: assert property (@(posedge clock) disable iff (!resetn)
    mode == vml_pkg::MODE_ZC && pend && tmo |=> level == $past(target))
    else $error("zero cross timeout did not apply level");
endmodule

/* logic/vml_ctrl.sv */
// file: level, silence, polarity and limiter control of the audio path
// assumes: byte register port, samples strobed once per sample period
`timescale 1ns/10ps
module vml_ctrl #(
  parameter int W   = 16,
  parameter int TMO = vml_pkg::ZC_TIMEOUT_CYC
) (
  input  logic                clock,
  input  logic                resetn,
  input  logic [7:0]          addr,
  input  logic [7:0]          wr_data,
  input  logic                wr_en,
  input  logic                rd_en,
  output logic [7:0]          rd_data,
  input  logic                in_valid,
  input  logic signed [W-1:0] in_a,
  input  logic signed [W-1:0] in_b,
  input  logic signed [W-1:0] in_bass,
  input  logic signed [W-1:0] in_low,
  input  logic signed [W-1:0] in_high,
  input  logic                dly_port_on,
  input  logic                adc_valid,
  input  logic signed [W-1:0] adc_in,
  output logic                out_valid,
  output logic signed [W-1:0] pwm_a,
  output logic signed [W-1:0] pwm_b,
  output logic signed [W-1:0] pwm_bass,
  output logic signed [W-1:0] aux_a,
  output logic signed [W-1:0] aux_b,
  output logic signed [W-1:0] aux_bass,
  output logic signed [W-1:0] low_out,
  output logic signed [W-1:0] high_out,
  output logic signed [W-1:0] dly_a,
  output logic signed [W-1:0] dly_b,
  output logic                adc_out_valid,
  output logic signed [W-1:0] adc_out
);
  logic [7:0]          ramp_ctrl;
  logic [7:0]          band_trim;
  logic [7:0]          main_level;
  logic [7:0]          channel_a_level;
  logic [7:0]          channel_b_level;
  logic [7:0]          bass_channel_level;
  logic [7:0]          silence_and_polarity;
  logic [7:0]          limiter_thresholds;
  logic [7:0]          status;
  logic [7:0]          next_rd;
  vml_pkg::vml_mode_t  mode;
  logic [9:0]          tgt [5];
  logic [9:0]          lvl [5];
  logic signed [W-1:0] din [5];
  logic signed [W-1:0] gout [5];
  logic                gval [5];
  logic [5:0]          lim [3];
  logic [2:0]          clip;
  logic [2:0]          quiet;
  logic [W-1:0]        upper_thr;
  logic [W-1:0]        lower_thr;
  logic [3:0]          woofer_band_trim;
  logic [3:0]          tweeter_band_trim;
  logic                peak_limiter_on;
  logic                limiter_global_link;

  function automatic logic signed [W-1:0] neg_sat(
    input logic signed [W-1:0] x
  );
    logic signed [W-1:0] r;
    r = -x;
    if (x == {1'b1, {(W-1){1'b0}}})
      r = {1'b0, {(W-1){1'b1}}};
    return r;
  endfunction

  // half-dB below +24 dB, limiter added, boost clamped at +24 dB
  function automatic logic [9:0] chan_target(
    input logic [7:0] m,
    input logic [7:0] c,
    input logic [5:0] l,
    input logic       sil
  );
    logic [10:0] s;
    logic [9:0]  t;
    s = {3'h0, m} + {3'h0, c} + {5'h00, l};
    t = 10'h000;
    if (sil || m == vml_pkg::MUTE_CODE || c == vml_pkg::MUTE_CODE)
      t = vml_pkg::MUTE_HDB;
    else if (s > vml_pkg::BOOST_HDB)
      t = 10'(s - vml_pkg::BOOST_HDB);
    if (t > vml_pkg::MUTE_HDB)
      t = vml_pkg::MUTE_HDB;
    return t;
  endfunction

  // level below full scale for a threshold code
  function automatic logic [W-1:0] thr_level(input logic [2:0] code);
    logic [15:0]   f;
    logic [W+15:0] p;
    f = 16'h040c;
    unique case (code)
      3'h0: f = 16'h7fff;
      3'h1: f = 16'h5a9d;
      3'h2: f = 16'h4027;
      3'h3: f = 16'h2d6b;
      3'h4: f = 16'h2027;
      3'h5: f = 16'h101d;
      3'h6: f = 16'h0814;
      default: f = 16'h040c;
    endcase
    p = (W+16)'({1'b0, {(W-1){1'b1}}}) * (W+16)'(f);
    return p[W+14:15];
  endfunction

  function automatic logic [W-1:0] mag(input logic signed [W-1:0] x);
    return x[W-1] ? neg_sat(x) : x;
  endfunction

  assign woofer_band_trim = band_trim[vml_pkg::F_WOOF +: 4];
  assign tweeter_band_trim = band_trim[3:0];
  assign peak_limiter_on = limiter_thresholds[vml_pkg::B_LIM_ON];
  assign limiter_global_link = limiter_thresholds[vml_pkg::B_LIM_LINK];
  assign upper_thr = thr_level(limiter_thresholds[vml_pkg::F_UPPER +: 3]);
  assign lower_thr = thr_level(limiter_thresholds[vml_pkg::F_LOWER +: 3]);

  always_comb
    unique case (ramp_ctrl[vml_pkg::F_RAMP +: 2])
      2'b00: mode = vml_pkg::MODE_IMM;
      2'b01: mode = vml_pkg::MODE_ZC;
      2'b10: mode = vml_pkg::MODE_RAMP;
      2'b11: mode = vml_pkg::MODE_RZC;
    endcase

  always_ff @(posedge clock)
    if (!resetn)
    begin
      ramp_ctrl <= vml_pkg::RST_RAMP;
      band_trim <= vml_pkg::RST_TRIM;
      main_level <= vml_pkg::RST_MAIN;
      channel_a_level <= vml_pkg::RST_LVL;
      channel_b_level <= vml_pkg::RST_LVL;
      bass_channel_level <= vml_pkg::RST_LVL;
      silence_and_polarity <= vml_pkg::RST_SIL;
      limiter_thresholds <= vml_pkg::RST_LIM;
    end
    else if (wr_en)
      unique case (addr)
        vml_pkg::OFS_RAMP: ramp_ctrl <= {wr_data[7:6], 6'h00};
        vml_pkg::OFS_TRIM: band_trim <= wr_data;
        vml_pkg::OFS_MAIN: main_level <= wr_data;
        vml_pkg::OFS_CHA: channel_a_level <= wr_data;
        vml_pkg::OFS_CHB: channel_b_level <= wr_data;
        vml_pkg::OFS_BASS: bass_channel_level <= wr_data;
        vml_pkg::OFS_SIL: silence_and_polarity <= wr_data;
        vml_pkg::OFS_LIM: limiter_thresholds <= wr_data;
        default: ;
      endcase

  always_comb
  begin
    status = 8'h00;
    for (int i = 0; i < 3; i++)
      status[i] = lim[i] != 6'h00;
    for (int i = 0; i < 5; i++)
      if (lvl[i] != tgt[i])
        status[3] = 1'b1;
  end

  always_comb
    unique case (addr)
      vml_pkg::OFS_RAMP: next_rd = ramp_ctrl;
      vml_pkg::OFS_TRIM: next_rd = band_trim;
      vml_pkg::OFS_MAIN: next_rd = main_level;
      vml_pkg::OFS_CHA: next_rd = channel_a_level;
      vml_pkg::OFS_CHB: next_rd = channel_b_level;
      vml_pkg::OFS_BASS: next_rd = bass_channel_level;
      vml_pkg::OFS_SIL: next_rd = silence_and_polarity;
      vml_pkg::OFS_LIM: next_rd = limiter_thresholds;
      vml_pkg::OFS_STAT: next_rd = status;
      default: next_rd = 8'h00;
    endcase

  always_ff @(posedge clock)
    if (!resetn)
      rd_data <= 8'h00;
    else if (rd_en)
      rd_data <= next_rd;
    else
      rd_data <= 8'h00;

  // per-path target levels
  always_comb
  begin
    tgt[0] = chan_target(main_level, channel_a_level, lim[0],
      silence_and_polarity[vml_pkg::B_SIL_A]);
    tgt[1] = chan_target(main_level, channel_b_level, lim[1],
      silence_and_polarity[vml_pkg::B_SIL_B]);
    tgt[2] = chan_target(main_level, bass_channel_level, lim[2],
      silence_and_polarity[vml_pkg::B_SIL_BASS]);
    tgt[3] = 10'(vml_pkg::BOOST_HDB) - 10'(woofer_band_trim > vml_pkg::WOOF_MAX ?
      vml_pkg::WOOF_MAX : woofer_band_trim);
    tgt[4] = 10'(vml_pkg::BOOST_HDB) - 10'(tweeter_band_trim);
  end

  assign din[0] = in_a;
  assign din[1] = in_b;
  assign din[2] = in_bass;
  assign din[3] = in_low;
  assign din[4] = in_high;

  for (genvar i = 0; i < 5; i++)
  begin : g_gain
    vml_gain_ch #(
      .W   (W),
      .TMO (TMO)
    ) u_gain (
      .clock     (clock),
      .resetn    (resetn),
      .mode      (mode),
      .target    (tgt[i]),
      .in_valid  (in_valid),
      .in_data   (din[i]),
      .out_valid (gval[i]),
      .out_data  (gout[i]),
      .level     (lvl[i])
    );
  end

  // peak limiter per channel
  for (genvar i = 0; i < 3; i++)
  begin : g_lim
    assign clip[i] = mag(gout[i]) > upper_thr;
    assign quiet[i] = mag(gout[i]) < lower_thr;
    always_ff @(posedge clock)
      if (!resetn || !peak_limiter_on)
        lim[i] <= 6'h00;
      else if (gval[i])
      begin
        if ((limiter_global_link ? |clip : clip[i]) && lim[i] != vml_pkg::LIM_MAX)
          lim[i] <= lim[i] + 6'h01;
        else if (quiet[i] && lim[i] != 6'h00)
          lim[i] <= lim[i] - 6'h01;
      end
  end

  always_ff @(posedge clock)
    if (!resetn)
    begin
      out_valid <= 1'b0;
      aux_a <= '0;
      aux_b <= '0;
      aux_bass <= '0;
      low_out <= '0;
      high_out <= '0;
    end
    else
    begin
      out_valid <= gval[0];
      if (gval[0])
      begin
        aux_a <= gout[0];
        aux_b <= gout[1];
        aux_bass <= gout[2];
        low_out <= gout[3];
        high_out <= gout[4];
      end
    end

  always_ff @(posedge clock)
    if (!resetn)
    begin
      pwm_a <= '0;
      pwm_b <= '0;
      pwm_bass <= '0;
    end
    else if (gval[0])
    begin
      pwm_a <= silence_and_polarity[vml_pkg::B_INV_A] ?
               neg_sat(gout[0]) : gout[0];
      pwm_b <= silence_and_polarity[vml_pkg::B_INV_B] ?
               neg_sat(gout[1]) : gout[1];
      pwm_bass <= silence_and_polarity[vml_pkg::B_INV_BASS] ?
                  neg_sat(gout[2]) : gout[2];
    end

  // delay port copies raw input while dly_port_on, zero otherwise; silence never mutes it
  always_ff @(posedge clock)
    if (!resetn)
    begin
      dly_a <= '0;
      dly_b <= '0;
    end
    else if (in_valid)
    begin
      dly_a <= dly_port_on ? in_a : '0;
      dly_b <= dly_port_on ? in_b : '0;
    end

  always_ff @(posedge clock)
    if (!resetn)
    begin
      adc_out_valid <= 1'b0;
      adc_out <= '0;
    end
    else
    begin
      adc_out_valid <= adc_valid;
      if (adc_valid)
      begin
        if (silence_and_polarity[vml_pkg::B_SIL_ADC])
          adc_out <= '0;
        else if (silence_and_polarity[vml_pkg::B_INV_ADC])
          adc_out <= neg_sat(adc_in);
        else
          adc_out <= adc_in;
      end
    end

  main_mute_a: assert property (@(posedge clock) disable iff (!resetn)
    main_level == vml_pkg::MUTE_CODE |-> tgt[0] == vml_pkg::MUTE_HDB &&
    tgt[1] == vml_pkg::MUTE_HDB && tgt[2] == vml_pkg::MUTE_HDB)
    else $error("main mute code did not mute all channels");
  chan_mute_a: assert property (@(posedge clock) disable iff (!resetn)
    channel_a_level == vml_pkg::MUTE_CODE && main_level != vml_pkg::MUTE_CODE
    && !silence_and_polarity[vml_pkg::B_SIL_A] |-> tgt[0] ==
    vml_pkg::MUTE_HDB && (tgt[1] != vml_pkg::MUTE_HDB ||
    channel_b_level == vml_pkg::MUTE_CODE || silence_and_polarity[1]))
    else $error("channel mute code reached the wrong channel");
  bass_unity_a: assert property (@(posedge clock) disable iff (!resetn)
    main_level == 8'h30 && bass_channel_level == 8'h30 && lim[2] == 6'h00
    && !silence_and_polarity[vml_pkg::B_SIL_BASS] |-> tgt[2] == 10'h030)
    else $error("bass unity code not at unity gain");
  adc_flip_a: assert property (@(posedge clock) disable iff (!resetn)
    adc_valid && silence_and_polarity[7:7] == 1'b1 &&
    !silence_and_polarity[vml_pkg::B_SIL_ADC] && adc_in == 16'sh0100
    |=> adc_out == -16'sh0100 && adc_out_valid)
    else $error("converter sample not negated");
  adc_sil_a: assert property (@(posedge clock) disable iff (!resetn)
    adc_valid && silence_and_polarity[vml_pkg::B_SIL_ADC] |=> adc_out == '0)
    else $error("converter silence not applied");
  pwm_inv_a: assert property (@(posedge clock) disable iff (!resetn)
    out_valid && $past(silence_and_polarity[vml_pkg::B_INV_A]) |->
    pwm_a == neg_sat(aux_a))
    else $error("channel pwm polarity not inverted against aux");
  bass_inv_a: assert property (@(posedge clock) disable iff (!resetn)
    out_valid && !$past(silence_and_polarity[vml_pkg::B_INV_BASS]) |->
    pwm_bass == aux_bass)
    else $error("bass pwm inverted without flip bit");
  dly_pass_a: assert property (@(posedge clock) disable iff (!resetn)
    in_valid && dly_port_on |=> dly_a == $past(in_a))
    else $error("delay output did not pass raw sample");
  lim_off_a: assert property (@(posedge clock) disable iff (!resetn)
    !peak_limiter_on |=> lim[0] == 6'h00 && lim[1] == 6'h00 && lim[2] == 6'h00)
    else $error("limiter attenuating while disabled");
endmodule

/* tb/tb_top.sv */
// testbench: register port, audio strobes and converter path of vml_ctrl
// assumes: 40 MHz clock, synchronous active-low reset, short zc timeout
`timescale 1ns/10ps
module tb_top;
  logic               clock;
  logic               resetn;
  logic [7:0]         addr;
  logic [7:0]         wr_data;
  logic               wr_en;
  logic               rd_en;
  logic [7:0]         rd_data;
  logic               in_valid;
  logic signed [15:0] in_a, in_b, in_bass, in_low, in_high, adc_in;
  logic               dly_port_on;
  logic               adc_valid;
  logic               out_valid;
  logic               adc_out_valid;
  logic signed [15:0] pwm_a, pwm_b, pwm_bass, aux_a, aux_b, aux_bass;
  logic signed [15:0] low_out, high_out, dly_a, dly_b, adc_out;
  int                 failures;
  int                 num_checks;

  vml_ctrl #(.W(16), .TMO(50)) i_vml_ctrl (
    .clock(clock), .resetn(resetn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .in_valid(in_valid), .in_a(in_a), .in_b(in_b), .in_bass(in_bass),
    .in_low(in_low), .in_high(in_high), .dly_port_on(dly_port_on),
    .adc_valid(adc_valid), .adc_in(adc_in), .out_valid(out_valid),
    .pwm_a(pwm_a), .pwm_b(pwm_b), .pwm_bass(pwm_bass),
    .aux_a(aux_a), .aux_b(aux_b), .aux_bass(aux_bass),
    .low_out(low_out), .high_out(high_out), .dly_a(dly_a),
    .dly_b(dly_b), .adc_out_valid(adc_out_valid), .adc_out(adc_out)
  );

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input string n, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, m);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    check("rd_data", {8'h00, rd_data & m}, {8'h00, e});
  endtask

  // n samples, outputs of the last one are settled on return
  task automatic go(input int n, input logic [15:0] a, b, s);
    repeat (n)
    begin
      @(posedge clock);
      in_valid <= 1'b1;
      in_a <= a;
      in_b <= b;
      in_bass <= s;
      in_low <= a;
      in_high <= a;
      @(posedge clock);
      in_valid <= 1'b0;
      @(posedge clock);
      #1;
    end
    check("out_valid", {15'h0000, out_valid}, 16'h0001);
  endtask

  task automatic adc(input logic [15:0] x, input logic [15:0] e);
    @(posedge clock);
    adc_valid <= 1'b1;
    adc_in <= x;
    @(posedge clock);
    adc_valid <= 1'b0;
    #1;
    check("adc_out_valid", {15'h0000, adc_out_valid}, 16'h0001);
    check("adc_out", adc_out, e);
  endtask

  task automatic t_regs;
    rd(vml_pkg::OFS_TRIM, vml_pkg::RST_TRIM, 8'hff);
    rd(vml_pkg::OFS_MAIN, vml_pkg::RST_MAIN, 8'hff);
    rd(vml_pkg::OFS_CHA, vml_pkg::RST_LVL, 8'hff);
    rd(vml_pkg::OFS_CHB, vml_pkg::RST_LVL, 8'hff);
    rd(vml_pkg::OFS_BASS, vml_pkg::RST_LVL, 8'hff);
    rd(vml_pkg::OFS_SIL, vml_pkg::RST_SIL, 8'hff);
    rd(vml_pkg::OFS_LIM, vml_pkg::RST_LIM, 8'hff);
    wr(vml_pkg::OFS_CHB, 8'ha5);
    rd(vml_pkg::OFS_CHB, 8'ha5, 8'hff);
    wr(8'h60, 8'hff);
    rd(8'h60, 8'h00, 8'hff);
    wr(vml_pkg::OFS_CHB, 8'h30);
  endtask

  task automatic t_gain;
    go(2, 16'h0400, 16'h0400, 16'h0400);
    check("aux_a", aux_a, 16'h0400);
    check("aux_bass", aux_bass, 16'h0400);
    wr(vml_pkg::OFS_MAIN, 8'h3c);
    go(2, 16'h0400, 16'h0400, 16'h0400);
    check("aux_a", aux_a, 16'h0200);
    wr(vml_pkg::OFS_CHA, 8'h24);
    go(2, 16'h0400, 16'h0400, 16'h0400);
    check("aux_a", aux_a, 16'h0400);
    check("aux_b", aux_b, 16'h0200);
    wr(vml_pkg::OFS_MAIN, 8'h00);
    wr(vml_pkg::OFS_CHA, 8'h30);
    go(2, 16'h0100, 16'h1000, 16'h0100);
    check("aux_a", aux_a, 16'h1000);
    check("aux_b", aux_b, 16'h7fff);
    check("aux_bass", aux_bass, 16'h1000);
    wr(vml_pkg::OFS_MAIN, 8'h30);
    wr(vml_pkg::OFS_BASS, 8'h3c);
    wr(vml_pkg::OFS_CHA, vml_pkg::MUTE_CODE);
    go(2, 16'h0400, 16'h0400, 16'h0400);
    check("aux_bass", aux_bass, 16'h0200);
    check("pwm_a", pwm_a, 16'h0000);
    check("aux_b", aux_b, 16'h0400);
    wr(vml_pkg::OFS_CHA, 8'h30);
    wr(vml_pkg::OFS_BASS, 8'h30);
    wr(vml_pkg::OFS_MAIN, vml_pkg::MUTE_CODE);
    go(2, 16'h0400, 16'h0400, 16'h0400);
    check("aux_b", aux_b, 16'h0000);
    check("pwm_bass", pwm_bass, 16'h0000);
    wr(vml_pkg::OFS_MAIN, 8'h30);
  endtask

  task automatic t_sil;
    wr(vml_pkg::OFS_SIL, 8'h70);
    go(2, 16'h0400, 16'h0300, 16'h0200);
    check("pwm_a", pwm_a, 16'hfc00);
    check("pwm_b", pwm_b, 16'hfd00);
    check("aux_b", aux_b, 16'h0300);
    check("dly_b", dly_b, 16'h0300);
    check("pwm_bass", pwm_bass, 16'hfe00);
    check("aux_bass", aux_bass, 16'h0200);
    wr(vml_pkg::OFS_SIL, 8'h07);
    go(2, 16'h0400, 16'h0300, 16'h0200);
    check("aux_a", aux_a, 16'h0000);
    check("pwm_b", pwm_b, 16'h0000);
    check("dly_a", dly_a, 16'h0400);
    dly_port_on <= 1'b0;
    go(1, 16'h0400, 16'h0300, 16'h0200);
    check("dly_a", dly_a, 16'h0000);
    dly_port_on <= 1'b1;
    check("aux_bass", aux_bass, 16'h0000);
    wr(vml_pkg::OFS_SIL, 8'h00);
    go(2, 16'h0400, 16'h0300, 16'h0200);
    check("pwm_bass", pwm_bass, 16'h0200);
    wr(vml_pkg::OFS_SIL, 8'h80);
    adc(16'h0100, 16'hff00);
    wr(vml_pkg::OFS_SIL, 8'h08);
    adc(16'h0123, 16'h0000);
    wr(vml_pkg::OFS_SIL, 8'h00);
    adc(16'h0123, 16'h0123);
  endtask

  task automatic t_trim;
    wr(vml_pkg::OFS_TRIM, 8'h0c);
    go(2, 16'h0400, 16'h0400, 16'h0400);
    check("high_out", high_out, 16'h0800);
    check("low_out", low_out, 16'h0400);
    wr(vml_pkg::OFS_TRIM, 8'hc0);
    go(2, 16'h0400, 16'h0400, 16'h0400);
    check("low_out", low_out, 16'h0800);
    check("high_out", high_out, 16'h0400);
    wr(vml_pkg::OFS_TRIM, 8'h00);
  endtask

  task automatic t_modes;
    wr(vml_pkg::OFS_RAMP, 8'h80);
    wr(vml_pkg::OFS_SIL, 8'h01);
    go(1, 16'h0400, 16'h0400, 16'h0400);
    check("aux_a zero", {15'h0000, aux_a == 16'h0000}, 16'h0000);
    wr(vml_pkg::OFS_RAMP, 8'h00);
    wr(vml_pkg::OFS_SIL, 8'h00);
    go(2, 16'h0400, 16'h0400, 16'h0400);
    wr(vml_pkg::OFS_RAMP, 8'h40);
    wr(vml_pkg::OFS_MAIN, 8'h3c);
    go(1, 16'h0400, 16'h0400, 16'h0400);
    check("aux_a", aux_a, 16'h0400);
    repeat (60) @(posedge clock);
    go(1, 16'h0400, 16'h0400, 16'h0400);
    check("aux_a", aux_a, 16'h0200);
    wr(vml_pkg::OFS_MAIN, 8'h30);
    go(1, 16'h0000, 16'h0000, 16'h0000);
    go(1, 16'h0400, 16'h0400, 16'h0400);
    check("aux_a", aux_a, 16'h0400);
    wr(vml_pkg::OFS_RAMP, 8'hc0);
    wr(vml_pkg::OFS_MAIN, 8'h3c);
    go(1, 16'h0000, 16'h0000, 16'h0000);
    go(1, 16'h0400, 16'h0400, 16'h0400);
    check("aux_a full", {15'h0000, aux_a == 16'h0200}, 16'h0000);
    go(11, 16'h0000, 16'h0000, 16'h0000);
    go(1, 16'h0400, 16'h0400, 16'h0400);
    check("aux_a", aux_a, 16'h0200);
    wr(vml_pkg::OFS_MAIN, 8'h30);
    wr(vml_pkg::OFS_RAMP, 8'h00);
  endtask

  task automatic t_lim;
    wr(vml_pkg::OFS_LIM, 8'h3c);
    go(4, 16'h7000, 16'h1000, 16'h1000);
    rd(vml_pkg::OFS_STAT, 8'h00, 8'h07);
    wr(vml_pkg::OFS_LIM, 8'h1d);
    go(4, 16'h7000, 16'h1000, 16'h1000);
    rd(vml_pkg::OFS_STAT, 8'h00, 8'h07);
    wr(vml_pkg::OFS_LIM, 8'h3d);
    go(4, 16'h7000, 16'h1000, 16'h1000);
    rd(vml_pkg::OFS_STAT, 8'h01, 8'h07);
    go(8, 16'h1000, 16'h1000, 16'h1000);
    rd(vml_pkg::OFS_STAT, 8'h01, 8'h07);
    wr(vml_pkg::OFS_LIM, 8'h21);
    go(8, 16'h1000, 16'h1000, 16'h1000);
    rd(vml_pkg::OFS_STAT, 8'h00, 8'h07);
    wr(vml_pkg::OFS_LIM, 8'h3c);
    wr(vml_pkg::OFS_LIM, 8'h3f);
    go(4, 16'h7000, 16'h1000, 16'h1000);
    rd(vml_pkg::OFS_STAT, 8'h07, 8'h07);
    wr(vml_pkg::OFS_LIM, 8'h00);
  endtask

  initial
  begin
    #(25 * 20000);
    failures++;
    summarize();
  end

  initial
  begin
    failures = 0;
    num_checks = 0;
    resetn = 1'b0;
    {addr, wr_data, wr_en, rd_en, in_valid, adc_valid} = '0;
    {in_a, in_b, in_bass, in_low, in_high, adc_in} = '0;
    dly_port_on = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    check("pwm_a", pwm_a, 16'h0000);
    @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    wr(vml_pkg::OFS_RAMP, 8'h00);
    wr(vml_pkg::OFS_MAIN, 8'h30);
    t_gain();
    t_sil();
    t_trim();
    t_modes();
    t_lim();
    summarize();
  end
endmodule
